// file: inc/spl_cfg.svh
// Constants for the self-program enable and lock guard block.
`ifndef SPL_CFG_SVH
`define SPL_CFG_SVH
`define SPL_WINDOW_CYCLES   3'h4
`define SPL_CTL_STORE       0
`define SPL_CTL_ERASE       1
`define SPL_CTL_WRITE       2
`define SPL_CTL_LOCKSET     3
`define SPL_CTL_REENABLE    4
`define SPL_LOCK_RESET      8'hFF
`define SPL_LOCK_FIXED_MASK 8'hC0
`define SPL_BOOT_HI         5
`define SPL_BOOT_LO         4
`define SPL_APP_HI          3
`define SPL_APP_LO          2
`define SPL_MEM_HI          1
`define SPL_MEM_LO          0
`define SPL_FUSE_EXT_RESET  8'hFF
`define SPL_FUSE_HIGH_RESET 8'hFF
`define SPL_FUSE_LOW_RESET  8'hFF
`define SPL_PAGE_WORD_BITS  7
`define SPL_PAGE_WORDS      128
`endif

// file: inc/spl_pkg.sv
// Types shared by the self-program enable and lock guard block.
package spl_pkg;
	typedef enum logic [2:0] {
		SPL_OP_NONE   = 3'b000,
		SPL_OP_FILL   = 3'b001,
		SPL_OP_ERASE  = 3'b010,
		SPL_OP_WRITE  = 3'b011,
		SPL_OP_LOCK   = 3'b100,
		SPL_OP_REEN   = 3'b101
	} spl_op_t;
	typedef enum logic [1:0] {
		SPL_ST_IDLE = 2'b00,
		SPL_ST_ARM  = 2'b01,
		SPL_ST_BUSY = 2'b10
	} spl_state_t;
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic [15:0] data;
	} spl_store_t;
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic        from_boot;
	} spl_load_t;
	typedef struct packed {
		logic        start;
		spl_op_t     op;
		logic [7:0]  page;
		logic [15:0] data;
		logic [6:0]  word;
	} spl_mem_cmd_t;
endpackage

// file: verification/spl_core_model.sv
// Processor-side model issuing store and load instructions.
module spl_core_model
	import spl_pkg::*;
(
	input  wire logic                i_clk,
	output      spl_pkg::spl_store_t o_store,
	output      spl_pkg::spl_load_t  o_load,
	output      logic [15:0]         o_load_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		o_store = '0;
		o_load = '0;
		o_load_rdata = 16'hC3C3;
	end
	// Released fields show the inverse so stale values are never mistaken for live ones.
	task automatic store(input logic [15:0] a, input logic [15:0] d);
		o_store = {1'b1, a, d};
		@(posedge i_clk) #1;
		o_store = {1'b0, ~a, ~d};
	endtask
	task automatic load(input logic [15:0] a, input logic b);
		o_load = {1'b1, a, b};
		o_load_rdata = 16'h5A5A;
		@(posedge i_clk) #1;
		o_load = {1'b0, ~a, ~b};
		o_load_rdata = 16'hA5A5;
	endtask
endmodule

// file: verification/spl_guard_bench.sv
// Self-checking bench for the store-enable window and lock guard.
module spl_guard_bench;
	import spl_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk, i_reset_n, i_ctl_we, i_vectors_boot, i_exec_boot, i_mem_done, i_chip_erase;
	logic i_fuse_we, i_ext_lock_we, o_load_valid, o_irq_enable, o_ext_prog_ok, o_ext_verify_ok;
	logic [4:0] i_ctl_wdata, o_ctl;
	logic [1:0] i_fuse_sel;
	logic [6:0] i_buf_raddr;
	logic [7:0] i_fuse_wdata, i_ext_lock_wdata, o_lock, o_fuse_high, o_fuse_ext, o_fuse_low;
	logic [15:0] i_load_rdata, o_buf_rdata, o_load_data;
	spl_store_t i_store;
	spl_load_t i_load;
	spl_mem_cmd_t o_mem_cmd;
	int fails = 0;
	int n_tests = 0;
	logic [4:0] bad[5] = '{5'h07, 5'h02, 5'h0B, 5'h19, 5'h1F};
	logic [4:0] pv[2] = '{5'h03, 5'h05};
	spl_op_t po[2] = '{SPL_OP_ERASE, SPL_OP_WRITE};
	spl_core_model core (.i_clk, .o_store(i_store), .o_load(i_load), .o_load_rdata(i_load_rdata));
	spl_guard DUT (.i_clk, .i_reset_n, .i_ctl_we, .i_ctl_wdata, .i_store, .i_load, .i_load_rdata,
		.i_boot_start(16'hE000), .i_vectors_boot, .i_exec_boot, .i_mem_done, .i_chip_erase,
		.i_ext_prog(1'b0), .i_ext_verify(1'b0), .i_fuse_we, .i_fuse_sel, .i_fuse_wdata,
		.i_ext_lock_we, .i_ext_lock_wdata, .i_buf_raddr, .o_ctl, .o_mem_cmd, .o_buf_rdata,
		.o_lock, .o_fuse_ext, .o_fuse_high, .o_fuse_low, .o_load_data, .o_load_valid,
		.o_irq_enable, .o_ext_prog_ok, .o_ext_verify_ok);
	initial
	begin
		i_clk = 0;
		forever #5 i_clk = ~i_clk;
	end
	task automatic step(input int n = 1);
		repeat (n) @(posedge i_clk) #1;
	endtask
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic arm(input logic [4:0] v);
		i_ctl_we = 1;
		i_ctl_wdata = v;
		step();
		i_ctl_we = 0;
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		step();
		s = 0;
		step(3);
	endtask
	task automatic wrap_up;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic t_window;
		arm(5'h01);
		core.store(16'h0103, 16'hA5C3);
		step();
		chk("ctl", 0, o_ctl);
		arm(5'h01);
		step(4);
		core.store(16'h0102, 16'h1111);
		i_buf_raddr = 1;
		step();
		chk("buf", 16'hA5C3, o_buf_rdata);
		foreach (bad[i])
		begin
			arm(bad[i]);
			chk("bad", 0, o_ctl);
			step();
		end
	endtask
	task automatic t_page;
		foreach (pv[i])
		begin
			arm(pv[i]);
			core.store(16'h4280, 16'hFFFF);
			for (int k = 0; k < 3 && o_mem_cmd.start !== 1'b1; k++)
				step();
			chk("start", 1, o_mem_cmd.start);
			chk("page", 16'h0042, o_mem_cmd.page);
			chk("op", po[i], o_mem_cmd.op);
			step(3);
			chk("busy", 1, o_ctl[0]);
			i_mem_done = 1;
			step();
			i_mem_done = 0;
			step();
			chk("done", 0, o_ctl);
		end
	endtask
	task automatic t_section;
		core.load(16'h0100, 1);
		chk("open", 16'h5A5A, o_load_data);
		arm(5'h09);
		core.store(16'h0000, 16'h00F3);
		step(3);
		chk("lock", 16'h00F3, o_lock);
		arm(5'h03);
		core.store(16'h0200, 16'h0000);
		repeat (3)
		begin
			chk("nostart", 0, o_mem_cmd.start);
			step();
		end
		chk("ctl", 0, o_ctl);
		core.load(16'h0100, 1);
		chk("ld", 16'h8000, {o_load_valid, o_load_data[14:0]});
		i_vectors_boot = 1;
		step(2);
		chk("irq", 0, o_irq_enable);
		i_exec_boot = 1;
		step(2);
		chk("irq", 1, o_irq_enable);
		pulse(i_chip_erase);
		chk("erase", 16'h00FF, o_lock);
	endtask
	task automatic t_ext;
		i_fuse_sel = 1;
		i_fuse_wdata = 8'h99;
		pulse(i_fuse_we);
		chk("fuse", 16'h0099, o_fuse_high);
		i_fuse_sel = 2;
		i_fuse_wdata = 8'h3C;
		pulse(i_fuse_we);
		chk("fuse_low", 16'h003C, o_fuse_low);
		chk("fuse_ext", 16'h00FF, o_fuse_ext);
		i_ext_lock_wdata = 8'hFC;
		pulse(i_ext_lock_we);
		chk("lock", 16'h00FC, o_lock);
		chk("ok", 0, {o_ext_prog_ok, o_ext_verify_ok});
		i_fuse_wdata = 8'h00;
		pulse(i_fuse_we);
		chk("fuse", 16'h003C, o_fuse_low);
		pulse(i_chip_erase);
		chk("ok", 3, {o_ext_prog_ok, o_ext_verify_ok});
	endtask
	// Boot section in lock mode 3: stores, cross-section loads and interrupts are guarded.
	task automatic t_boot;
		i_ext_lock_wdata = 8'hCF;
		pulse(i_ext_lock_we);
		chk("lock", 16'h00CF, o_lock);
		arm(5'h03);
		core.store(16'hE100, 16'h0000);
		chk("nostart", 0, o_mem_cmd.start);
		step();
		chk("ctl", 0, o_ctl);
		core.load(16'hE100, 0);
		chk("ld", 0, o_load_data);
		chk("ldv", 1, o_load_valid);
		i_vectors_boot = 0;
		step(2);
		chk("irq", 0, o_irq_enable);
		i_exec_boot = 0;
		step(2);
		chk("irq", 1, o_irq_enable);
	endtask
	initial
	begin
		{i_ctl_we, i_vectors_boot, i_exec_boot, i_mem_done, i_chip_erase} = '0;
		{i_fuse_we, i_ext_lock_we, i_ctl_wdata, i_fuse_sel, i_buf_raddr, i_fuse_wdata} = '0;
		i_ext_lock_wdata = 8'hFF;
		i_reset_n = 0;
		step(5);
		i_reset_n = 1;
		chk("lock", 16'h00FF, o_lock);
		chk("fuse", 16'h00FF, o_fuse_high);
		chk("fuse_ext", 16'h00FF, o_fuse_ext);
		chk("fuse_low", 16'h00FF, o_fuse_low);
		t_window();
		t_page();
		t_section();
		t_ext();
		t_boot();
		wrap_up();
	end
	initial
	begin
		step(5000);
		fails++;
		wrap_up();
	end
endmodule

// file: verification/spl_guard_checker.sv
// Concurrent checks on the store-enable window and the lock outputs.
module spl_guard_checker
	import spl_pkg::*;
(
	input wire logic                  i_clk,
	input wire logic                  i_reset_n,
	input wire logic                  i_ctl_we,
	input wire logic [4:0]            i_ctl_wdata,
	input wire spl_pkg::spl_store_t   i_store,
	input wire spl_pkg::spl_load_t    i_load,
	input wire logic [15:0]           i_boot_start,
	input wire logic                  i_mem_done,
	input wire logic                  i_chip_erase,
	input wire logic [4:0]            o_ctl,
	input wire spl_pkg::spl_mem_cmd_t o_mem_cmd,
	input wire logic [7:0]            o_lock,
	input wire logic [15:0]           o_load_data,
	input wire logic                  o_load_valid,
	input wire logic                  o_ext_prog_ok,
	input wire logic                  o_ext_verify_ok
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	sequence arm_req(v);
		o_ctl == 5'h00 && i_ctl_we && i_ctl_wdata == v;
	endsequence
	sequence page_store;
		(o_ctl == 5'h03 || o_ctl == 5'h05) && i_store.valid && o_lock == 8'hFF;
	endsequence
	win_open_a: assert property (arm_req(5'h01) |=> o_ctl == 5'h01)
		else $error("store window did not open");
	win_close_a: assert property (arm_req(5'h01) ##1 (!i_store.valid)[*4] |=> o_ctl == 5'h00)
		else $error("store window did not close");
	bad_ctl_a: assert property (o_ctl == 5'h00 && i_ctl_we &&
		!(i_ctl_wdata inside {5'h01, 5'h03, 5'h05, 5'h09, 5'h11}) |=> o_ctl == 5'h00)
		else $error("illegal control pattern took effect");
	page_cmd_a: assert property (page_store |=> o_mem_cmd.start &&
		o_mem_cmd.page == $past(i_store.addr[15:8]) && o_mem_cmd.data == 16'h0000)
		else $error("page command wrong");
	busy_hold_a: assert property (o_mem_cmd.start ##1 !i_mem_done |-> o_ctl[0])
		else $error("enable dropped while busy");
	busy_clear_a: assert property (o_ctl[0] && (o_ctl[1] || o_ctl[2]) && i_mem_done
		|-> ##[1:2] o_ctl == 5'h00)
		else $error("enable not cleared after completion");
	lock_rise_a: assert property ((!i_chip_erase)[*3] |=> (o_lock & ~$past(o_lock)) == 8'h00)
		else $error("lock bit erased without chip erase");
	lock_top_a: assert property (o_lock[7:6] == 2'b11)
		else $error("lock top bits not one");
	boot_read_a: assert property (i_load.valid && !i_load.from_boot &&
		i_load.addr >= i_boot_start && !o_lock[5] |=> o_load_valid && o_load_data == 16'h0000)
		else $error("protected boot data returned");
	full_lock_a: assert property (o_lock[1:0] == 2'b00 ##1 o_lock[1:0] == 2'b00
		|-> !o_ext_prog_ok && !o_ext_verify_ok)
		else $error("full memory lock not applied");
	no_lock_a: assert property ((o_lock[1:0] == 2'b11)[*2] |-> o_ext_prog_ok && o_ext_verify_ok)
		else $error("restriction without memory lock");
endmodule
bind spl_guard spl_guard_checker u_chk (.i_clk, .i_reset_n, .i_ctl_we, .i_ctl_wdata, .i_store,
	.i_load, .i_boot_start, .i_mem_done, .i_chip_erase, .o_ctl, .o_mem_cmd, .o_lock,
	.o_load_data, .o_load_valid, .o_ext_prog_ok, .o_ext_verify_ok);

// file: verilog/spl_guard.sv
// Store-enable window, page buffer, lock byte and fuse storage with section guard.
`include "spl_cfg.svh"
module spl_guard
	import spl_pkg::*;
(
	input  wire logic                 i_clk,
	input  wire logic                 i_reset_n,
	input  wire logic                 i_ctl_we,
	input  wire logic [4:0]           i_ctl_wdata,
	input  wire spl_pkg::spl_store_t  i_store,
	input  wire spl_pkg::spl_load_t   i_load,
	input  wire logic [15:0]          i_load_rdata,
	input  wire logic [15:0]          i_boot_start,
	input  wire logic                 i_vectors_boot,
	input  wire logic                 i_exec_boot,
	input  wire logic                 i_mem_done,
	input  wire logic                 i_chip_erase,
	input  wire logic                 i_ext_prog,
	input  wire logic                 i_ext_verify,
	input  wire logic                 i_fuse_we,
	input  wire logic [1:0]           i_fuse_sel,
	input  wire logic [7:0]           i_fuse_wdata,
	input  wire logic                 i_ext_lock_we,
	input  wire logic [7:0]           i_ext_lock_wdata,
	input  wire logic [6:0]           i_buf_raddr,
	output      logic [4:0]           o_ctl,
	output      spl_pkg::spl_mem_cmd_t o_mem_cmd,
	output      logic [15:0]          o_buf_rdata,
	output      logic [7:0]           o_lock,
	output      logic [7:0]           o_fuse_ext,
	output      logic [7:0]           o_fuse_high,
	output      logic [7:0]           o_fuse_low,
	output      logic [15:0]          o_load_data,
	output      logic                 o_load_valid,
	output      logic                 o_irq_enable,
	output      logic                 o_ext_prog_ok,
	output      logic                 o_ext_verify_ok
);
	spl_state_t  state;
	spl_state_t  next_state;
	spl_op_t     op;
	logic [2:0]  window;
	logic [7:0]  lock;
	logic [7:0]  fuse [3];
	logic [15:0] page_buf [`SPL_PAGE_WORDS];
	wire logic       pattern_ok;
	wire spl_op_t    pattern_op;
	wire logic       store_hit;
	wire logic       target_boot;
	wire logic       store_ok;
	wire logic       load_ok;
	wire logic       irq_ok;
	wire logic       do_fill;
	wire logic       do_lock;
	wire logic       do_page;
	wire logic       mem_lock_lo;
	wire logic       mem_lock_both;
	wire logic [6:0] fill_word;
	wire logic [7:0] store_page;

	function automatic spl_op_t decode_ctl(input logic [4:0] v);
		unique case (v)
			5'h01:   decode_ctl = SPL_OP_FILL;
			5'h03:   decode_ctl = SPL_OP_ERASE;
			5'h05:   decode_ctl = SPL_OP_WRITE;
			5'h09:   decode_ctl = SPL_OP_LOCK;
			5'h11:   decode_ctl = SPL_OP_REEN;
			default: decode_ctl = SPL_OP_NONE;
		endcase
	endfunction

	function automatic logic [4:0] op_bits(input spl_op_t o);
		unique case (o)
			SPL_OP_FILL:  op_bits = 5'h01;
			SPL_OP_ERASE: op_bits = 5'h03;
			SPL_OP_WRITE: op_bits = 5'h05;
			SPL_OP_LOCK:  op_bits = 5'h09;
			SPL_OP_REEN:  op_bits = 5'h11;
			default:      op_bits = 5'h00;
		endcase
	endfunction

	// A write is honoured only when idle and when it is one of the permitted patterns.
	assign pattern_op = decode_ctl(i_ctl_wdata);
	assign pattern_ok = i_ctl_we && (state == SPL_ST_IDLE) && (pattern_op != SPL_OP_NONE);
	assign store_hit  = i_store.valid && (state == SPL_ST_ARM);
	assign target_boot = i_store.addr[15:1] >= i_boot_start[15:1];
	assign fill_word  = i_store.addr[`SPL_PAGE_WORD_BITS:1];
	assign store_page = i_store.addr[15:8];
	assign mem_lock_lo   = !lock[`SPL_MEM_LO];
	assign mem_lock_both = !lock[`SPL_MEM_LO] && !lock[`SPL_MEM_HI];
	assign do_fill = store_hit && (op == SPL_OP_FILL);
	assign do_lock = store_hit && (op == SPL_OP_LOCK);
	// A refused page operation finishes at once and leaves memory alone.
	assign do_page = store_hit && ((op == SPL_OP_ERASE) || (op == SPL_OP_WRITE)) && store_ok;

	spl_lock_decode u_decode (
		.i_lock         (lock),
		.i_target_boot  (target_boot),
		.i_exec_boot    (i_exec_boot),
		.i_vectors_boot (i_vectors_boot),
		.o_store_ok     (store_ok),
		.o_load_ok      (load_ok),
		.o_irq_ok       (irq_ok)
	);

	// Load guard: a refused read returns zero with no error.
	wire logic load_from_boot;
	wire logic load_allowed;
	assign load_from_boot = i_load.addr[15:1] >= i_boot_start[15:1];
	spl_lock_decode u_load_decode (
		.i_lock         (lock),
		.i_target_boot  (load_from_boot),
		.i_exec_boot    (i_load.from_boot),
		.i_vectors_boot (i_vectors_boot),
		.o_store_ok     (),
		.o_load_ok      (load_allowed),
		.o_irq_ok       ()
	);

	always_comb
	begin
		next_state = state;
		unique case (state)
			SPL_ST_IDLE:
				if (pattern_ok)
					next_state = SPL_ST_ARM;
			SPL_ST_ARM:
				if (do_page)
					next_state = SPL_ST_BUSY;
				else if (store_hit || window == 3'h1)
					next_state = SPL_ST_IDLE;
			SPL_ST_BUSY:
				if (i_mem_done)
					next_state = SPL_ST_IDLE;
			default:
				next_state = SPL_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state  <= SPL_ST_IDLE;
			op     <= SPL_OP_NONE;
			window <= 3'h0;
		end
		else
		begin
			state <= next_state;
			if (pattern_ok)
			begin
				op     <= pattern_op;
				window <= `SPL_WINDOW_CYCLES;
			end
			else if (state == SPL_ST_ARM && window != 3'h0)
				window <= window - 3'h1;
			if (next_state == SPL_ST_IDLE)
				op <= SPL_OP_NONE;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_ctl <= 5'h00;
		else
			o_ctl <= (next_state == SPL_ST_IDLE) ? 5'h00 :
				(pattern_ok ? op_bits(pattern_op) : op_bits(op));
	end

	// Temporary page buffer; a fill into a locked section is dropped.
	always_ff @(posedge i_clk)
	begin
		if (do_fill && store_ok)
			page_buf[fill_word] <= i_store.data;
		o_buf_rdata <= page_buf[i_buf_raddr];
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_mem_cmd <= '0;
		else
		begin
			o_mem_cmd.start <= do_page;
			if (do_page)
			begin
				o_mem_cmd.op   <= op;
				o_mem_cmd.page <= store_page;
				o_mem_cmd.word <= 7'h00;
				o_mem_cmd.data <= 16'h0000;
			end
		end
	end

	// Lock bits only ever move toward programmed except on reset or chip erase.
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			lock <= `SPL_LOCK_RESET;
		else if (i_chip_erase)
			lock <= `SPL_LOCK_RESET;
		else if (do_lock)
			lock <= lock & (i_store.data[7:0] | `SPL_LOCK_FIXED_MASK | 8'h03);
		else if (i_ext_lock_we)
		begin
			if (mem_lock_both)
				lock <= lock & (i_ext_lock_wdata | 8'hFC);
			else
				lock <= lock & (i_ext_lock_wdata | `SPL_LOCK_FIXED_MASK);
		end
	end

	// Fuse bytes: extended, high, low; locked once the low memory lock is programmed.
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_fuse
			always_ff @(posedge i_clk or negedge i_reset_n)
			begin
				if (!i_reset_n)
					fuse[g] <= (g == 0) ? `SPL_FUSE_EXT_RESET :
						((g == 1) ? `SPL_FUSE_HIGH_RESET : `SPL_FUSE_LOW_RESET);
				else if (i_fuse_we && i_fuse_sel == 2'(g) && !mem_lock_lo)
					fuse[g] <= i_fuse_wdata;
			end
		end
	endgenerate

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_lock          <= `SPL_LOCK_RESET;
			o_fuse_ext      <= `SPL_FUSE_EXT_RESET;
			o_fuse_high     <= `SPL_FUSE_HIGH_RESET;
			o_fuse_low      <= `SPL_FUSE_LOW_RESET;
			o_load_data     <= 16'h0000;
			o_load_valid    <= 1'b0;
			o_irq_enable    <= 1'b1;
			o_ext_prog_ok   <= 1'b1;
			o_ext_verify_ok <= 1'b1;
		end
		else
		begin
			o_lock          <= lock | `SPL_LOCK_FIXED_MASK;
			o_fuse_ext      <= fuse[0];
			o_fuse_high     <= fuse[1];
			o_fuse_low      <= fuse[2];
			o_load_valid    <= i_load.valid;
			o_load_data     <= (i_load.valid && load_allowed) ? i_load_rdata : 16'h0000;
			o_irq_enable    <= irq_ok;
			o_ext_prog_ok   <= !mem_lock_lo;
			o_ext_verify_ok <= !mem_lock_both;
		end
	end

	wire logic unused_ok;
	assign unused_ok = i_ext_prog ^ i_ext_verify;
endmodule

// file: verilog/spl_lock_decode.sv
// Section access decoder from the lock byte and the fetch location.
`include "spl_cfg.svh"
module spl_lock_decode
	import spl_pkg::*;
(
	input  wire logic [7:0] i_lock,
	input  wire logic       i_target_boot,
	input  wire logic       i_exec_boot,
	input  wire logic       i_vectors_boot,
	output      logic       o_store_ok,
	output      logic       o_load_ok,
	output      logic       o_irq_ok
);
	wire logic app_hi;
	wire logic app_lo;
	wire logic boot_hi;
	wire logic boot_lo;
	wire logic app_no_store;
	wire logic app_no_load;
	wire logic boot_no_store;
	wire logic boot_no_load;
	assign app_hi  = i_lock[`SPL_APP_HI];
	assign app_lo  = i_lock[`SPL_APP_LO];
	assign boot_hi = i_lock[`SPL_BOOT_HI];
	assign boot_lo = i_lock[`SPL_BOOT_LO];
	// Modes 2 and 3 share a programmed low bit; modes 3 and 4 a programmed high bit.
	assign app_no_store  = !app_lo;
	assign app_no_load   = !app_hi;
	assign boot_no_store = !boot_lo;
	assign boot_no_load  = !boot_hi;
	// Both pairs unprogrammed leave every access open.
	assign o_store_ok = i_target_boot ? !boot_no_store : !app_no_store;
	assign o_load_ok  = (i_target_boot == i_exec_boot) ? 1'b1 :
		(i_target_boot ? !boot_no_load : !app_no_load);
	assign o_irq_ok = !((i_vectors_boot && !i_exec_boot && app_no_load)
		|| (!i_vectors_boot && i_exec_boot && boot_no_load));
endmodule
